// File: design/lec_pkg.sv
// Package for the lookup engine control zero register bank.
// Assumes a single 40 MHz switch core clock and an AXI4-Lite master.
`default_nettype none
package lec_pkg;
  // ****************************************************************
  // Register map and fields
  // ****************************************************************
  localparam logic [11:0] LEC_CTL0_OFS      = 12'h310;
  localparam logic [11:0] LEC_STAT_OFS      = 12'h314;
  localparam int          LEC_VLAN_EN_BIT   = 7;
  localparam int          LEC_DROP_VID_BIT  = 6;
  localparam int          LEC_AGE_HI        = 5;
  localparam int          LEC_AGE_LO        = 3;
  localparam int          LEC_RSVD_MC_BIT   = 2;
  localparam int          LEC_HASH_HI       = 1;
  localparam int          LEC_HASH_LO       = 0;
  localparam logic [7:0]  LEC_CTL0_RST      = 8'h61;
  localparam int          LEC_DIRECT_BITS   = 10;

  // ****************************************************************
  // Hash select codes
  // ****************************************************************
  typedef enum logic [1:0] {
    LEC_HASH_DIRECT  = 2'h0,
    LEC_HASH_CRC     = 2'h1,
    LEC_HASH_XOR     = 2'h2,
    LEC_HASH_DIRECT2 = 2'h3
  } lec_hash_t;

  // AXI responses.
  localparam logic [1:0]  LEC_RESP_OKAY     = 2'h0;
  localparam logic [1:0]  LEC_RESP_SLVERR   = 2'h2;
endpackage : lec_pkg
`default_nettype wire

// File: design/lec_ctl0.sv
// Lookup engine control zero register with its AXI4-Lite slave.
// Assumes the lookup datapath consumes the decoded controls on the same clock.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`default_nettype none
module lec_ctl0 (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // AXI4-Lite slave
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Lookup engine side
  input  wire logic        unknown_vid_fwd_en,
  input  wire logic        invalid_vid_frame,
  input  wire logic        dyn_entry_update,
  input  wire logic [7:0]  age_period,
  input  wire logic [47:0] dest_addr,
  input  wire logic [9:0]  crc_hash,
  input  wire logic [9:0]  xor_hash,
  output logic             vlan_mode_en,
  output logic             invalid_vid_drop,
  output logic             invalid_vid_to_host,
  output logic [2:0]       entry_age_count,
  output logic [10:0]      aging_periods,
  output logic             rsvd_mc_lookup_en,
  output logic [9:0]       dyn_table_index
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0]  ctl;
    logic        aw_held;
    logic [11:0] awaddr;
    logic        w_held;
    logic [7:0]  wdata;
    logic        wstrb0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [2:0]  age_q;
    logic [9:0]  idx_q;
  } lec_state_t;

  lec_state_t st_r;
  lec_state_t st_nxt;
  logic [11:0] wa;
  logic [7:0]  wd;
  logic        ws;
  logic        do_wr;
  logic        drop_c;
  logic [9:0]  idx_c;

  assign s_axi_awready = !st_r.aw_held && !st_r.bvalid;
  assign s_axi_wready  = !st_r.w_held && !st_r.bvalid;
  assign s_axi_arready = !st_r.rvalid;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    wa     = st_r.aw_held ? st_r.awaddr : s_axi_awaddr;
    wd     = st_r.w_held ? st_r.wdata : s_axi_wdata[7:0];
    ws     = st_r.w_held ? st_r.wstrb0 : s_axi_wstrb[0];
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.aw_held = 1'b1;
      st_nxt.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.w_held = 1'b1;
      st_nxt.wdata  = s_axi_wdata[7:0];
      st_nxt.wstrb0 = s_axi_wstrb[0];
    end
    do_wr = (st_r.aw_held || (s_axi_awvalid && s_axi_awready))
         && (st_r.w_held || (s_axi_wvalid && s_axi_wready));
    if (do_wr) begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.bresp   = lec_pkg::LEC_RESP_OKAY;
      if (wa[11:2] == lec_pkg::LEC_CTL0_OFS[11:2]) begin
        if (ws) begin
          st_nxt.ctl = wd;
        end
      end else if (wa[11:2] != lec_pkg::LEC_STAT_OFS[11:2]) begin
        st_nxt.bresp = lec_pkg::LEC_RESP_SLVERR;
      end
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = lec_pkg::LEC_RESP_OKAY;
      st_nxt.rdata  = 32'h0;
      if (s_axi_araddr[11:2] == lec_pkg::LEC_CTL0_OFS[11:2]) begin
        st_nxt.rdata = {24'h0, st_r.ctl};
      end else if (s_axi_araddr[11:2] == lec_pkg::LEC_STAT_OFS[11:2]) begin
        // Shows the block's live lookup state: last loaded age and index.
        st_nxt.rdata = {19'h0, st_r.age_q, st_r.idx_q};
      end else begin
        st_nxt.rresp = lec_pkg::LEC_RESP_SLVERR;
      end
    end
    // Age count captured into the entry being updated.
    if (dyn_entry_update) begin
      st_nxt.age_q = st_r.ctl[lec_pkg::LEC_AGE_HI:lec_pkg::LEC_AGE_LO];
      st_nxt.idx_q = idx_c;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r     <= '0;
      st_r.ctl <= lec_pkg::LEC_CTL0_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Decoded controls
  // ****************************************************************
  always_comb begin
    case (lec_pkg::lec_hash_t'(st_r.ctl[lec_pkg::LEC_HASH_HI:lec_pkg::LEC_HASH_LO]))
      lec_pkg::LEC_HASH_CRC: idx_c = crc_hash;
      lec_pkg::LEC_HASH_XOR: idx_c = xor_hash;
      default:               idx_c = dest_addr[lec_pkg::LEC_DIRECT_BITS-1:0];
    endcase
  end

  // Unknown-VLAN forwarding takes the frame away from the drop decision.
  assign drop_c = st_r.ctl[lec_pkg::LEC_DROP_VID_BIT] && !unknown_vid_fwd_en;

  assign vlan_mode_en        = st_r.ctl[lec_pkg::LEC_VLAN_EN_BIT];
  assign invalid_vid_drop    = invalid_vid_frame && drop_c;
  assign invalid_vid_to_host = invalid_vid_frame && !st_r.ctl[lec_pkg::LEC_DROP_VID_BIT]
                               && !unknown_vid_fwd_en;
  assign entry_age_count     = st_r.age_q;
  // Aging time is the age count times the period, in period units.
  assign aging_periods       = 11'(st_r.ctl[lec_pkg::LEC_AGE_HI:lec_pkg::LEC_AGE_LO])
                               * 11'(age_period);
  assign rsvd_mc_lookup_en   = st_r.ctl[lec_pkg::LEC_RSVD_MC_BIT];
  assign dyn_table_index     = st_r.idx_q;
  assign s_axi_bvalid        = st_r.bvalid;
  assign s_axi_bresp         = st_r.bresp;
  assign s_axi_rvalid        = st_r.rvalid;
  assign s_axi_rdata         = st_r.rdata;
  assign s_axi_rresp         = st_r.rresp;

  // ****************************************************************
  // Checks
  // ****************************************************************
  vlan_en_reg_a: assert property (@(posedge clk) disable iff (rst)
    (do_wr && wa[11:2] == lec_pkg::LEC_CTL0_OFS[11:2] && ws)
      |=> vlan_mode_en == $past(wd[7]))
    else $error("vlan enable not written");
  drop_route_a: assert property (@(posedge clk) disable iff (rst)
    !(invalid_vid_drop && invalid_vid_to_host))
    else $error("invalid vid both dropped and forwarded");
  drop_select_a: assert property (@(posedge clk) disable iff (rst)
    (invalid_vid_frame && !unknown_vid_fwd_en)
      |-> invalid_vid_drop == st_r.ctl[6] && invalid_vid_to_host == !st_r.ctl[6])
    else $error("invalid vid routing does not follow the drop bit");
  unknown_override_a: assert property (@(posedge clk) disable iff (rst)
    unknown_vid_fwd_en |-> !invalid_vid_drop && !invalid_vid_to_host)
    else $error("unknown vid forwarding not overriding");
  age_load_a: assert property (@(posedge clk) disable iff (rst)
    dyn_entry_update |=> entry_age_count == $past(st_r.ctl[5:3]))
    else $error("age count not loaded");
  aging_time_a: assert property (@(posedge clk) disable iff (rst)
    age_period == 8'h1 |-> aging_periods == {8'h0, st_r.ctl[5:3]})
    else $error("aging time wrong");
  rsvd_mc_a: assert property (@(posedge clk) disable iff (rst)
    (do_wr && wa[11:2] == lec_pkg::LEC_CTL0_OFS[11:2] && ws)
      |=> rsvd_mc_lookup_en == $past(wd[2]))
    else $error("reserved multicast enable not written");
  hash_sel_a: assert property (@(posedge clk) disable iff (rst)
    (dyn_entry_update && st_r.ctl[1:0] == 2'h2) |=> dyn_table_index == $past(xor_hash))
    else $error("xor hash not used");
  hash_direct_a: assert property (@(posedge clk) disable iff (rst)
    (dyn_entry_update && (st_r.ctl[1:0] == 2'h0 || st_r.ctl[1:0] == 2'h3))
      |=> dyn_table_index == $past(dest_addr[9:0]))
    else $error("direct index not used");
  read_data_a: assert property (@(posedge clk) disable iff (rst)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr[11:2] == lec_pkg::LEC_CTL0_OFS[11:2])
      |=> s_axi_rdata == {24'h0, $past(st_r.ctl)})
    else $error("control read data wrong");
  write_resp_a: assert property (@(posedge clk) disable iff (rst)
    do_wr |=> s_axi_bvalid)
    else $error("write response missing");
  wr_cov: cover property (@(posedge clk) disable iff (rst) do_wr ##1 s_axi_bvalid);
  rd_cov: cover property (@(posedge clk) disable iff (rst) s_axi_rvalid && s_axi_rready);
  drop_cov: cover property (@(posedge clk) disable iff (rst) invalid_vid_drop);
  unk_cov: cover property (@(posedge clk) disable iff (rst) unknown_vid_fwd_en && invalid_vid_frame);
  crc_cov: cover property (@(posedge clk) disable iff (rst)
    dyn_entry_update && st_r.ctl[1:0] == 2'h1);

endmodule : lec_ctl0
`default_nettype wire

// File: tb/lec_ctl0_test.sv
// Self-checking bench for the lookup engine control zero register bank.
// Assumes lec_pkg and lec_ctl0 are compiled first; the bench drives every port itself.
`default_nettype none
module lec_ctl0_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        clk = 1'b0, rst = 1'b1;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        unk_en = 1'b0, bad_vid = 1'b0, upd = 1'b0;
  logic [7:0]  period = 8'h0;
  logic [47:0] dest = 48'h0;
  logic [9:0]  crc = 10'h2A5, xorh = 10'h15A;
  logic        vlan_en, drop, to_host, rsvd_en;
  logic [2:0]  age;
  logic [10:0] aging;
  logic [9:0]  idx;
  logic [31:0] d;
  logic [1:0]  r;
  int          miscompares = 0, checks = 0, cycles = 0;
  always #12.5 clk = ~clk;
  lec_ctl0 DUT (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .unknown_vid_fwd_en(unk_en), .invalid_vid_frame(bad_vid), .dyn_entry_update(upd),
    .age_period(period), .dest_addr(dest), .crc_hash(crc), .xor_hash(xorh),
    .vlan_mode_en(vlan_en), .invalid_vid_drop(drop), .invalid_vid_to_host(to_host),
    .entry_age_count(age), .aging_periods(aging), .rsvd_mc_lookup_en(rsvd_en),
    .dyn_table_index(idx));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic test_done;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // Address and data are offered together and each is dropped once taken.
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s);
    @(posedge clk);
    awaddr <= a; wdata <= v; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    d = rdata; r = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic pulse;
    @(posedge clk) upd <= 1'b1;
    @(posedge clk) upd <= 1'b0;
    @(negedge clk);
  endtask : pulse
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      miscompares++;
      test_done();
    end
  end
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(lec_pkg::LEC_CTL0_OFS);
    chk(d, 32'h0000_0061, "reset value");
    chk({vlan_en, rsvd_en}, 32'h0, "reset outputs");
    chk({age, idx}, 32'h0, "reset capture");
    $display("reset test done");
    wr(lec_pkg::LEC_CTL0_OFS, 32'h0000_00A1, 4'h1);
    chk(r, lec_pkg::LEC_RESP_OKAY, "write resp");
    bad_vid <= 1'b1;
    @(negedge clk);
    chk({vlan_en, drop, to_host}, 32'h5, "vlan on, forward to host");
    @(posedge clk) unk_en <= 1'b1;
    @(negedge clk);
    chk({drop, to_host}, 32'h0, "unknown forwarding wins");
    $display("vlan test done");
    wr(lec_pkg::LEC_CTL0_OFS, 32'h0000_006D, 4'h1);
    unk_en <= 1'b0; period <= 8'h07;
    pulse();
    chk({vlan_en, drop, to_host, rsvd_en}, 32'h5, "drop and rsvd");
    chk(age, 32'h5, "captured age");
    chk(aging, 32'h23, "aging time");
    rd(lec_pkg::LEC_CTL0_OFS);
    chk(d, 32'h0000_006D, "readback");
    $display("age test done");
    dest <= 48'h1234_5678_9CC3;
    for (int c = 0; c < 4; c++) begin
      wr(lec_pkg::LEC_CTL0_OFS, 32'h20 | c, 4'h1);
      pulse();
      chk(idx, (c == 1) ? 32'h2A5 : (c == 2) ? 32'h15A : 32'h0C3, "hash index");
      chk(age, 32'h4, "age count loaded");
    end
    $display("hash test done");
    rd(lec_pkg::LEC_STAT_OFS);
    chk(d, 32'h0000_10C3, "status capture");
    wr(lec_pkg::LEC_STAT_OFS, 32'h0000_00FF, 4'hF);
    chk(r, lec_pkg::LEC_RESP_OKAY, "status write resp");
    // A write with the low strobe off must leave the byte alone.
    wr(lec_pkg::LEC_CTL0_OFS, 32'h0000_00FF, 4'hE);
    rd(lec_pkg::LEC_CTL0_OFS);
    chk(d, 32'h0000_0023, "masked write");
    period <= 8'h01;
    @(negedge clk);
    chk(aging, 32'h4, "aging time unit period");
    rd(12'h400);
    chk(r, lec_pkg::LEC_RESP_SLVERR, "unmapped read resp");
    chk(d, 32'h0, "unmapped read data");
    wr(12'h400, 32'h0, 4'hF);
    chk(r, lec_pkg::LEC_RESP_SLVERR, "unmapped write");
    $display("access test done");
    test_done();
  end
endmodule : lec_ctl0_test
`default_nettype wire
